// *** logic/cpi_pkg.sv ***
// Purpose: shared constants and types of the config protect and id block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   register indices times four give the byte address
package cpi_pkg;

  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_USER_ID0   = 16'h8000;
  localparam logic [15:0] IDX_USER_ID3   = 16'h8003;
  localparam logic [15:0] IDX_REVISION   = 16'h8005;
  localparam logic [15:0] IDX_DEVICE     = 16'h8006;
  localparam logic [15:0] IDX_CFG3       = 16'h8008;
  localparam logic [15:0] IDX_WDOG_CTRL  = 16'h8009;
  localparam logic [15:0] IDX_WINDOW     = 16'h800a;
  localparam logic [15:0] IDX_PROTECT    = 16'h800b;

  // config word three field positions
  localparam int CPS_LSB = 0;
  localparam int WDOG_ENABLE_CONFIG_LSB = 5;
  localparam int CWS_LSB = 8;
  // wdog control register field positions
  localparam int CTRL_SEN_BIT = 0;
  localparam int CTRL_PER_LSB = 2;
  // protect status field positions
  localparam int PROT_CP_BIT = 0;
  localparam int PROT_WRT_LSB = 1;
  localparam int PROT_LOAD_BIT = 3;

  // watchdog period and window codes
  localparam logic [4:0] PER_SW_CODE   = 5'h1f;
  localparam logic [4:0] PER_SW_RESET  = 5'h0b;
  localparam logic [4:0] PER_MAX_CODE  = 5'h12;
  localparam logic [4:0] PER_SHORT     = 5'h00;
  localparam logic [4:0] DIV_EXP_BASE  = 5'h05;
  localparam logic [2:0] WIN_SW_CODE   = 3'h7;
  localparam logic [2:0] WIN_SW_ALT    = 3'h6;
  localparam logic [2:0] WIN_FULL      = 3'h7;

  // watchdog enable modes
  localparam logic [1:0] WEN_ALWAYS = 2'h3;
  localparam logic [1:0] WEN_RUN    = 2'h2;
  localparam logic [1:0] WEN_SOFT   = 2'h1;
  localparam logic [1:0] WEN_OFF    = 2'h0;

  // self-write protection select codes and region ends
  localparam logic [1:0]  WRT_OFF   = 2'h3;
  localparam logic [1:0]  WRT_BOOT  = 2'h2;
  localparam logic [1:0]  WRT_HALF  = 2'h1;
  localparam logic [12:0] END_BOOT  = 13'h01ff;
  localparam logic [12:0] END_HALF  = 13'h0fff;

  // reset values
  localparam logic [13:0] UID_RESET  = 14'h3fff;
  localparam logic [13:0] CFG3_RESET = 14'h3fff;

  typedef enum logic [1:0] {
    BOOT_LOAD = 2'b00, BOOT_SETTLE = 2'b01, BOOT_RUN = 2'b11
  } cpi_boot_e;

  typedef enum logic [1:0] {
    EXT_IDLE = 2'b00, EXT_MEM = 2'b01, EXT_ACK = 2'b11
  } cpi_ext_e;

  // nonvolatile configuration as presented by the storage array
  typedef struct packed {
    logic        cp_n;
    logic [1:0]  self_write_protect_sel;
    logic [13:0] cfg3;
  } cpi_nvm_s;

  // external programmer request, stable while its request is high
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [13:0] wdata;
  } cpi_ext_req_s;

endpackage

// *** logic/cpi_sync3.sv ***
// Purpose: three-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk_sys_in
// Notes:   output moves only once flops two and three agree
`timescale 1ns/1ps
module cpi_sync3 (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  // pin side
  input  wire logic pin_in,
  // clock side
  output logic      level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } cpi_sync_s;

  cpi_sync_s q;
  cpi_sync_s next_q;

  // stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    next_q = q;
    next_q.s1 = pin_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.s2 == q.s3) begin
      next_q.lvl = q.s3;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level_out = q.lvl;

endmodule

// *** logic/cpi_config_protect.sv ***
// Purpose: config latch, code and write protection, user and chip ids
// Assumes: programmer address and data are stable while its request is high
// Notes on behaviour
// - five-bit watchdog period field, bits 4:0
// - period codes map to 2^(5+code), else 1:32
// - smallest window delay only under software control
// - code protect blocks external program memory access, reads zero
// - internal access unaffected; self-writes see protection
// - two-bit field sizes self-write protected region
// - four user id words, software read/write
// - 14-bit device and revision id words
// - id words are read-only, writes ignored
// - two-bit watchdog enable mode select
`timescale 1ns/1ps
module cpi_config_protect
  import cpi_pkg::*;
#(
  // arbitrary neutral identification values
  parameter logic [13:0] DEVICE_ID   = 14'h2a55,
  parameter logic [13:0] REVISION_ID = 14'h1001
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         arst_n_in,
  // apb slave
  input  wire logic         psel_in,
  input  wire logic         penable_in,
  input  wire logic         pwrite_in,
  input  wire logic [31:0]  paddr_in,
  input  wire logic [31:0]  pwdata_in,
  output logic              pready_out,
  output logic [31:0]       prdata_out,
  output logic              pslverr_out,
  // nonvolatile configuration
  input  wire cpi_nvm_s     nvm_in,
  // processor side
  input  wire logic         sleep_in,
  input  wire logic         self_wr_req_in,
  input  wire logic [12:0]  self_wr_addr_in,
  output logic              cpu_release_out,
  output logic              self_wr_allow_out,
  output logic              self_wr_deny_out,
  // watchdog settings
  output logic              wdog_enable_out,
  output logic [4:0]        wdog_period_select_out,
  output logic [4:0]        wdog_div_exp_out,
  output logic              wdog_period_sw_out,
  output logic [2:0]        wdog_window_out,
  output logic              wdog_window_sw_out,
  // external programmer
  input  wire logic         ext_req_in,
  input  wire cpi_ext_req_s ext_in,
  output logic              ext_ack_out,
  output logic [13:0]       ext_rdata_out,
  // program memory port for external access
  output logic              pm_req_out,
  output logic              pm_we_out,
  output logic [12:0]       pm_addr_out,
  output logic [13:0]       pm_wdata_out,
  input  wire logic         pm_ack_in,
  input  wire logic [13:0]  pm_rdata_in
);

  typedef struct packed {
    cpi_boot_e        boot;
    cpi_ext_e         ext;
    logic [13:0]      cfg3;
    logic             cp_n;
    logic [1:0]       self_write_protect_sel;
    logic [4:0]       period;
    logic             sen;
    logic [2:0]       window;
    logic [3:0][13:0] uid;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             ext_ack;
    logic [13:0]      ext_rdata;
    logic             pm_req;
    logic             pm_we;
    logic [12:0]      pm_addr;
    logic [13:0]      pm_wdata;
    logic             wr_allow;
    logic             wr_deny;
    logic             wdog_en;
    logic [4:0]       div_exp;
  } cpi_state_s;

  cpi_state_s q;
  cpi_state_s next_q;
  logic       ext_req_lvl;

  // programmer request arrives from another clock domain
  cpi_sync3 u_req_sync (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .pin_in     (ext_req_in),
    .level_out  (ext_req_lvl)
  );

  // index match on an aligned word address
  function automatic logic is_idx(input logic [31:0] a,
                                  input logic [15:0] idx);
    is_idx = (a[31:18] == 14'h0) && (a[17:2] == idx) &&
             (a[1:0] == 2'b00);
  endfunction

  // divider exponent for a period code; out-of-table codes act as 1:32
  function automatic logic [4:0] div_exp(input logic [4:0] code);
    if (code <= PER_MAX_CODE) begin
      div_exp = 5'(DIV_EXP_BASE + code);
    end else begin
      div_exp = DIV_EXP_BASE;
    end
  endfunction

  // period in force at power-on for a configured code
  function automatic logic [4:0] por_period(input logic [4:0] code);
    if (code == PER_SW_CODE) begin
      por_period = PER_SW_RESET;
    end else if (code > PER_MAX_CODE) begin
      por_period = PER_SHORT;
    end else begin
      por_period = code;
    end
  endfunction

  // self-write protection test for a program memory word
  function automatic logic is_protected(input logic [1:0]  sel,
                                        input logic [12:0] a);
    unique case (sel)
      WRT_OFF:  is_protected = 1'b0;
      WRT_BOOT: is_protected = (a <= END_BOOT);
      WRT_HALF: is_protected = (a <= END_HALF);
      default:  is_protected = 1'b1;
    endcase
  endfunction

  // id space word for an index within 8000h..8006h
  function automatic logic [13:0] id_word(input cpi_state_s s,
                                          input logic [15:0] idx);
    if (idx >= IDX_USER_ID0 && idx <= IDX_USER_ID3) begin
      id_word = s.uid[idx[1:0]];
    end else if (idx == IDX_REVISION) begin
      id_word = REVISION_ID;
    end else if (idx == IDX_DEVICE) begin
      id_word = DEVICE_ID;
    end else begin
      id_word = 14'h0;
    end
  endfunction

  // single next-state process for the whole block
  always_comb begin
    logic [4:0]  cps;
    logic [2:0]  cws;
    logic [15:0] aidx;
    logic        hit;
    logic        apb_wr;
    cps = '0;
    cws = '0;
    aidx = paddr_in[17:2];
    hit = 1'b0;
    apb_wr = 1'b0;
    next_q = q;
    cps = q.cfg3[CPS_LSB +: 5];
    cws = q.cfg3[CWS_LSB +: 3];

    // latch config
    // configuration is caught after reset release, before the cpu runs
    unique case (q.boot)
      BOOT_LOAD: begin
        next_q.cfg3 = nvm_in.cfg3;
        next_q.cp_n = nvm_in.cp_n;
        next_q.self_write_protect_sel = nvm_in.self_write_protect_sel;
        next_q.boot = BOOT_SETTLE;
      end
      BOOT_SETTLE: begin
        next_q.period = por_period(cps);
        // window at power-on
        // software code 110 reads as 111; 000 gives the 87.5% delay
        if (cws == WIN_SW_ALT) begin
          next_q.window = WIN_FULL;
        end else begin
          next_q.window = cws;
        end
        next_q.boot = BOOT_RUN;
      end
      BOOT_RUN: begin
        next_q.boot = BOOT_RUN;
      end
      default: begin
        next_q.boot = BOOT_LOAD;
      end
    endcase

    // apb setup cycle prepares the answer for the access edge
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    if (psel_in && !penable_in) begin
      next_q.pready = 1'b1;
      next_q.prdata = '0;
      if (paddr_in[31:18] == 14'h0 && paddr_in[1:0] == 2'b00 &&
          aidx >= IDX_USER_ID0 && aidx <= IDX_DEVICE &&
          aidx != 16'h8004) begin
        hit = 1'b1;
        next_q.prdata = {18'h0, id_word(q, aidx)};
        if (pwrite_in && aidx >= IDX_REVISION) begin
          next_q.pslverr = 1'b1;
        end
      end
      if (is_idx(paddr_in, IDX_CFG3)) begin
        hit = 1'b1;
        next_q.prdata = {18'h0, q.cfg3};
        next_q.pslverr = pwrite_in;
      end
      if (is_idx(paddr_in, IDX_WDOG_CTRL)) begin
        hit = 1'b1;
        next_q.prdata[CTRL_SEN_BIT] = q.sen;
        next_q.prdata[CTRL_PER_LSB +: 5] = q.period;
      end
      if (is_idx(paddr_in, IDX_WINDOW)) begin
        hit = 1'b1;
        next_q.prdata[2:0] = q.window;
      end
      if (is_idx(paddr_in, IDX_PROTECT)) begin
        hit = 1'b1;
        next_q.prdata[PROT_CP_BIT] = q.cp_n;
        next_q.prdata[PROT_WRT_LSB +: 2] = q.self_write_protect_sel;
        next_q.prdata[PROT_LOAD_BIT] = (q.boot == BOOT_RUN);
        next_q.pslverr = pwrite_in;
      end
      if (!hit) begin
        next_q.pslverr = 1'b1;
      end
    end

    // writes land only at the access edge of an accepted transfer
    apb_wr = psel_in && penable_in && q.pready && pwrite_in &&
             !q.pslverr;
    if (apb_wr) begin
      if (aidx >= IDX_USER_ID0 && aidx <= IDX_USER_ID3) begin
        next_q.uid[aidx[1:0]] = pwdata_in[13:0];
      end
      if (is_idx(paddr_in, IDX_WDOG_CTRL)) begin
        next_q.sen = pwdata_in[CTRL_SEN_BIT];
        if (cps == PER_SW_CODE) begin
          next_q.period = pwdata_in[CTRL_PER_LSB +: 5];
        end
      end
      // software window
      // only the software codes unlock the window, incl. smallest delay
      if (is_idx(paddr_in, IDX_WINDOW) && cws[2:1] == WIN_SW_CODE[2:1]) begin
        next_q.window = pwdata_in[2:0];
      end
    end

    unique case (q.cfg3[WDOG_ENABLE_CONFIG_LSB +: 2])
      WEN_ALWAYS: next_q.wdog_en = 1'b1;
      WEN_RUN:    next_q.wdog_en = !sleep_in;
      WEN_SOFT:   next_q.wdog_en = q.sen;
      WEN_OFF:    next_q.wdog_en = 1'b0;
    endcase
    if (q.boot != BOOT_RUN) begin
      next_q.wdog_en = 1'b0;
    end
    next_q.div_exp = div_exp(q.period);

    // region select
    // a request before the cpu is released is always refused
    next_q.wr_allow = self_wr_req_in && (q.boot == BOOT_RUN) &&
                      !is_protected(q.self_write_protect_sel, self_wr_addr_in);
    next_q.wr_deny = self_wr_req_in && !next_q.wr_allow;

    // external programmer, four-phase request and acknowledge
    unique case (q.ext)
      EXT_IDLE: begin
        if (ext_req_lvl && q.boot == BOOT_RUN) begin
          next_q.ext_rdata = '0;
          if (ext_in.addr[15]) begin
            next_q.ext_rdata = id_word(q, ext_in.addr);
            if (!ext_in.we) begin
              next_q.ext_rdata = id_word(q, ext_in.addr);
            end else if (ext_in.addr <= IDX_USER_ID3 && q.cp_n) begin
              next_q.ext_rdata = '0;
              next_q.uid[ext_in.addr[1:0]] = ext_in.wdata;
            end else begin
              next_q.ext_rdata = '0;
            end
            next_q.ext_ack = 1'b1;
            next_q.ext = EXT_ACK;
          end else if (!q.cp_n) begin
            next_q.ext_ack = 1'b1;
            next_q.ext = EXT_ACK;
          end else begin
            next_q.pm_req = 1'b1;
            next_q.pm_we = ext_in.we;
            next_q.pm_addr = ext_in.addr[12:0];
            next_q.pm_wdata = ext_in.wdata;
            next_q.ext = EXT_MEM;
          end
        end
      end
      EXT_MEM: begin
        if (pm_ack_in) begin
          next_q.pm_req = 1'b0;
          next_q.ext_rdata = q.pm_we ? 14'h0 : pm_rdata_in;
          next_q.ext_ack = 1'b1;
          next_q.ext = EXT_ACK;
        end
      end
      EXT_ACK: begin
        if (!ext_req_lvl) begin
          next_q.ext_ack = 1'b0;
          next_q.ext = EXT_IDLE;
        end
      end
      default: begin
        next_q.ext = EXT_IDLE;
        next_q.ext_ack = 1'b0;
        next_q.pm_req = 1'b0;
      end
    endcase
  end

  // state register; uid reset models an erased id area
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
      q.boot <= BOOT_LOAD;
      q.ext <= EXT_IDLE;
      q.cfg3 <= CFG3_RESET;
      q.cp_n <= 1'b1;
      q.self_write_protect_sel <= WRT_OFF;
      q.period <= PER_SW_RESET;
      q.window <= WIN_FULL;
      q.uid <= {4{UID_RESET}};
      q.div_exp <= 5'(DIV_EXP_BASE + PER_SW_RESET);
    end else begin
      q <= next_q;
    end
  end

  // outputs come from the state register; cpu_release_out and the two software flags are decoded from it
  assign pready_out = q.pready;
  assign prdata_out = q.prdata;
  assign pslverr_out = q.pslverr;
  assign cpu_release_out = (q.boot == BOOT_RUN);
  assign self_wr_allow_out = q.wr_allow;
  assign self_wr_deny_out = q.wr_deny;
  assign wdog_enable_out = q.wdog_en;
  assign wdog_period_select_out = q.period;
  assign wdog_div_exp_out = q.div_exp;
  assign wdog_period_sw_out = (q.cfg3[CPS_LSB +: 5] == PER_SW_CODE);
  assign wdog_window_out = q.window;
  assign wdog_window_sw_out = (q.cfg3[CWS_LSB + 1 +: 2] == WIN_SW_CODE[2:1]);
  assign ext_ack_out = q.ext_ack;
  assign ext_rdata_out = q.ext_rdata;
  assign pm_req_out = q.pm_req;
  assign pm_we_out = q.pm_we;
  assign pm_addr_out = q.pm_addr;
  assign pm_wdata_out = q.pm_wdata;

endmodule

// *** tb/cpi_config_protect_sva.sv ***
// Purpose: port checks of the config protect and id block
// Assumes: nvm_in only moves while reset is held
// Notes:   most checks wait for the processor release
`timescale 1ns/1ps
module cpi_config_protect_sva
  import cpi_pkg::*;
(
  // clock, reset and apb
  input wire logic         clk_sys_in,
  input wire logic         arst_n_in,
  input wire logic         psel_in,
  input wire logic         penable_in,
  input wire logic         pwrite_in,
  input wire logic [31:0]  paddr_in,
  input wire logic         pready_out,
  input wire logic         pslverr_out,
  // configuration and processor side
  input wire cpi_nvm_s     nvm_in,
  input wire logic         self_wr_req_in,
  input wire logic [12:0]  self_wr_addr_in,
  input wire logic         cpu_release_out,
  input wire logic         self_wr_allow_out,
  input wire logic         wdog_enable_out,
  input wire logic [4:0]   wdog_period_select_out,
  input wire logic [4:0]   wdog_div_exp_out,
  input wire logic         wdog_period_sw_out,
  input wire logic [2:0]   wdog_window_out,
  input wire logic         wdog_window_sw_out,
  // programmer side
  input wire cpi_ext_req_s ext_in,
  input wire logic         ext_ack_out,
  input wire logic [13:0]  ext_rdata_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  // short names; wen and self_write_protect_sel are latched fields, static while running
  wire            rel  = cpu_release_out;
  wire [1:0]      wen  = nvm_in.cfg3[6:5];
  wire [1:0]      self_write_protect_sel  = nvm_in.self_write_protect_sel;
  wire [4:0]      psel = wdog_period_select_out;

  property p_period_flag;
    rel |-> wdog_period_sw_out == (nvm_in.cfg3[4:0] == PER_SW_CODE);
  endproperty
  a_period_flag: assert property (p_period_flag)
    else $error("period software flag wrong");
  // divider trails the period code by one edge
  property p_div;
    rel |-> wdog_div_exp_out == (($past(psel) > PER_MAX_CODE) ?
      DIV_EXP_BASE : $past(psel) + DIV_EXP_BASE);
  endproperty
  a_div: assert property (p_div)
    else $error("divider exponent wrong");
  property p_win_hold;
    rel && !wdog_window_sw_out |-> wdog_window_out == nvm_in.cfg3[10:8];
  endproperty
  a_win_hold: assert property (p_win_hold)
    else $error("window moved without software control");
  property p_cp_zero;
    ext_ack_out && !nvm_in.cp_n && !ext_in.addr[15] |-> ext_rdata_out == '0;
  endproperty
  a_cp_zero: assert property (p_cp_zero)
    else $error("protected read not zero");
  property p_selfwr;
    self_wr_req_in && rel |=> self_wr_allow_out == (self_write_protect_sel == WRT_OFF ||
      (self_write_protect_sel == WRT_BOOT && $past(self_wr_addr_in) > END_BOOT) ||
      (self_write_protect_sel == WRT_HALF && $past(self_wr_addr_in) > END_HALF));
  endproperty
  a_selfwr: assert property (p_selfwr)
    else $error("self write verdict wrong");
  // enable follows one edge after the processor release
  property p_enable;
    rel && $past(rel) && (wen == WEN_ALWAYS || wen == WEN_OFF) |->
      wdog_enable_out == (wen == WEN_ALWAYS);
  endproperty
  a_enable: assert property (p_enable)
    else $error("watchdog enable wrong");
  property p_ro_id;
    psel_in && penable_in && pready_out && pwrite_in &&
      paddr_in[31:2] inside {30'h8005, 30'h8006} |-> pslverr_out;
  endproperty
  a_ro_id: assert property (p_ro_id)
    else $error("id write not refused");
  property p_release;
    $rose(cpu_release_out) |-> $past(arst_n_in, 2);
  endproperty
  a_release: assert property (p_release)
    else $error("release before config latched");
endmodule

bind cpi_config_protect cpi_config_protect_sva u_sva (.*);

// *** tb/cpi_prog_model.sv ***
// Purpose: programmer tool and program memory beside the block
// Assumes: four-phase programmer handshake, memory answers slowly
// Notes:   released lines show inverted data, never a held value
`timescale 1ns/1ps
module cpi_prog_model
  import cpi_pkg::*;
(
  // clock
  input  wire logic        clk_sys_in,
  // programmer pins
  output cpi_ext_req_s     ext_out,
  output logic             ext_req_out,
  input  wire logic        ext_ack_in,
  input  wire logic [13:0] ext_rdata_in,
  // program memory port
  input  wire logic        pm_req_in,
  input  wire logic [12:0] pm_addr_in,
  output logic             pm_ack_out,
  output logic [13:0]      pm_rdata_out
);
  int wait_cnt = 0;

  // idle levels at time zero
  initial begin
    ext_req_out = 1'b0;
    ext_out = '0;
    pm_ack_out = 1'b0;
    pm_rdata_out = '0;
  end

  // memory waits four cycles; data is a function of the address
  always @(posedge clk_sys_in) begin
    pm_ack_out <= 1'b0;
    pm_rdata_out <= ~pm_rdata_out;
    wait_cnt <= 0;
    if (pm_req_in && !pm_ack_out) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == 3) begin
        pm_ack_out <= 1'b1;
        pm_rdata_out <= {1'b0, pm_addr_in} ^ 14'h2a00;
      end
    end
  end

  // one full four-phase transfer; fields held until ack falls
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [13:0] d, output logic [13:0] q);
    @(posedge clk_sys_in);
    ext_out <= '{w, a, d};
    ext_req_out <= 1'b1;
    do @(posedge clk_sys_in); while (ext_ack_in !== 1'b1);
    q = ext_rdata_in;
    ext_req_out <= 1'b0;
    do @(posedge clk_sys_in); while (ext_ack_in !== 1'b0);
    ext_out <= ~ext_out;
  endtask
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the config protect and id block
// Assumes: programmer and memory come from cpi_prog_model
// Notes:   each nvm setting needs its own reset, it is latched once
`timescale 1ns/1ps
module tb_top
  import cpi_pkg::*;
;
  localparam logic [13:0] DEV = 14'h1a2b; // arbitrary id value
  localparam logic [13:0] REVISION_ID_BITS = 14'h0c3d; // arbitrary id value
  logic clk_sys_in, arst_n_in, psel_in, penable_in, pwrite_in, e;
  logic [31:0] paddr_in, pwdata_in, prdata_out, q;
  logic pready_out, pslverr_out, sleep_in, self_wr_req_in;
  logic cpu_release_out, self_wr_allow_out, self_wr_deny_out;
  logic wdog_enable_out, wdog_period_sw_out, wdog_window_sw_out;
  logic [4:0] wdog_period_select_out, wdog_div_exp_out;
  logic [2:0] wdog_window_out;
  logic [12:0] self_wr_addr_in, pm_addr_out;
  logic [13:0] ext_rdata_out, pm_wdata_out, pm_rdata_in, r;
  logic ext_req_in, ext_ack_out, pm_req_out, pm_we_out, pm_ack_in;
  cpi_nvm_s nvm_in;
  cpi_ext_req_s ext_in;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  cpi_config_protect #(.DEVICE_ID(DEV), .REVISION_ID(REVISION_ID_BITS)) DUT (.*);
  cpi_prog_model PM (.clk_sys_in, .ext_out(ext_in), .ext_req_out(ext_req_in),
    .ext_ack_in(ext_ack_out), .ext_rdata_in(ext_rdata_out),
    .pm_req_in(pm_req_out), .pm_addr_in(pm_addr_out),
    .pm_ack_out(pm_ack_in), .pm_rdata_out(pm_rdata_in));

  // 200 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // hang guard, far above the length of all scenarios
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask

  // apb master: setup, access until pready, then release
  task automatic apb(input logic w, input logic [15:0] i,
                     input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {14'h0000, i, 2'b00};
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // nvm only changes under reset; wait for the processor release
  task automatic rst(input cpi_nvm_s v);
    @(posedge clk_sys_in);
    arst_n_in <= 1'b0;
    nvm_in <= v;
    repeat (4) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    do @(posedge clk_sys_in); while (cpu_release_out !== 1'b1);
  endtask

  task automatic t_ids();
    rst('{1'b1, WRT_BOOT, CFG3_RESET});
    apb(1'b0, IDX_REVISION, 32'h0);
    chk("rev", {18'h0, REVISION_ID_BITS}, q);
    apb(1'b1, IDX_DEVICE, 32'h3fff);
    chk("dev wr err", 32'h1, e);
    apb(1'b1, IDX_REVISION, 32'h0);
    chk("rev wr err", 32'h1, e);
    apb(1'b0, IDX_DEVICE, 32'h0);
    chk("dev", {18'h0, DEV}, q);
    apb(1'b0, 16'h8004, 32'h0);
    chk("gap err", 32'h1, e);
    PM.xfer(1'b0, IDX_DEVICE, 14'h0, r);
    chk("ext dev", DEV, r);
  endtask

  task automatic t_uid();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, IDX_USER_ID0 + 16'(i), 32'h0);
      chk("uid reset", UID_RESET, q);
      apb(1'b1, IDX_USER_ID0 + 16'(i), 32'h0a0 + i);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, IDX_USER_ID0 + 16'(i), 32'h0);
      chk("uid", 32'h0a0 + i, q);
    end
  endtask

  // boot region ends at 1ff: last protected word, then first free one
  task automatic t_selfwr();
    @(posedge clk_sys_in);
    self_wr_req_in <= 1'b1;
    self_wr_addr_in <= END_BOOT;
    @(posedge clk_sys_in);
    self_wr_addr_in <= END_BOOT + 13'h1;
    @(posedge clk_sys_in);
    chk("deny 1ff", 32'h1, self_wr_deny_out);
    self_wr_req_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("allow 200", 32'h1, self_wr_allow_out);
  endtask

  task automatic t_ext();
    PM.xfer(1'b0, 16'h0123, 14'h0, r);
    chk("ext pm", 14'h0123 ^ 14'h2a00, r);
    PM.xfer(1'b1, 16'h0456, 14'h1234, r);
    chk("pm wr", {1'b1, 13'h0456, 14'h1234},
        {pm_we_out, pm_addr_out, pm_wdata_out});
  endtask

  task automatic t_cp();
    rst('{1'b0, WRT_OFF, CFG3_RESET});
    PM.xfer(1'b0, 16'h0123, 14'h0, r);
    chk("cp read", 32'h0, r);
    PM.xfer(1'b1, 16'h0456, 14'h1234, r);
    chk("cp wr", 32'h0, {pm_req_out, pm_we_out, pm_addr_out});
    apb(1'b0, IDX_PROTECT, 32'h0);
    chk("prot", {28'h0, 1'b1, WRT_OFF, 1'b0}, q);
    @(posedge clk_sys_in);
    self_wr_req_in <= 1'b1;
    self_wr_addr_in <= 13'h0000;
    @(posedge clk_sys_in);
    self_wr_req_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("cp self wr", 32'h1, self_wr_allow_out);
  endtask

  // per case: window, enable mode, period code; then software writes
  task automatic t_wdog();
    logic [9:0] cf [4] = '{10'h37f, 10'h2d2, 10'h233, 10'h000};
    int d0 [4] = '{16, 23, 5, 5};
    int d1 [4] = '{23, 23, 5, 5};
    int w1 [4] = '{0, 5, 4, 0};
    int p1 [4] = '{18, 18, 0, 0};
    logic [3:0] en0 = 4'b0001;
    logic [3:0] en1 = 4'b0101;
    logic [3:0] sl = 4'b0010;
    for (int i = 0; i < 4; i++) begin
      sleep_in <= sl[i];
      rst('{1'b1, WRT_OFF, {3'b111, cf[i][9:7], 1'b1, cf[i][6:0]}});
      @(posedge clk_sys_in);
      chk("div", d0[i], wdog_div_exp_out);
      chk("en", en0[i], wdog_enable_out);
      apb(1'b1, IDX_WDOG_CTRL, 32'h49);
      apb(1'b1, IDX_WINDOW, 32'h0);
      repeat (3) @(posedge clk_sys_in);
      chk("div sw", d1[i], wdog_div_exp_out);
      chk("en sw", en1[i], wdog_enable_out);
      chk("win", w1[i], wdog_window_out);
      chk("per", p1[i], wdog_period_select_out);
      chk("sw", (i == 0) ? 2'b11 : 2'b00,
          {wdog_period_sw_out, wdog_window_sw_out});
    end
  endtask

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // time-zero inputs, then the scenarios in order
  initial begin
    arst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 32'h0;
    pwdata_in = 32'h0;
    nvm_in = '1;
    sleep_in = 1'b0;
    self_wr_req_in = 1'b0;
    self_wr_addr_in = 13'h0;
    t_ids();
    t_uid();
    t_selfwr();
    t_ext();
    t_cp();
    t_wdog();
    finish_test();
  end
endmodule
